// ==== shared/agcc_pkg.sv ====
// constants, register layout and helper tables for the gain loop config
`default_nettype none
package agcc_pkg;

	localparam logic [7:0] AGCC_CTRL_OFS = 8'h1c;
	localparam logic [7:0] AGCC_CTRL_RST = 8'h91;

	localparam int AGCC_HYST_LSB = 6;
	localparam int AGCC_WAIT_LSB = 4;
	localparam int AGCC_HOLD_LSB = 2;
	localparam int AGCC_FILT_LSB = 0;

	localparam logic [5:0] AGCC_WAIT_UNIT = 6'h08;
	localparam logic [4:0] AGCC_OOK_STEP_DB = 5'h04;

	localparam logic [1:0] AGCC_HOLD_NONE = 2'h0;
	localparam logic [1:0] AGCC_HOLD_SYNC = 2'h1;
	localparam logic [1:0] AGCC_HOLD_ANA = 2'h2;
	localparam logic [1:0] AGCC_HOLD_ALL = 2'h3;

	typedef struct packed {
		logic [1:0] hyst;
		logic [1:0] wait_sel;
		logic [1:0] hold;
		logic [1:0] filt;
	} agcc_ctrl_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} agcc_reg_req_t;

	typedef enum logic {
		AGCC_ST_ACCUM = 1'b0,
		AGCC_ST_SETTLE = 1'b1
	} agcc_state_t;

	// margin above target before gain is lowered
	function automatic logic [3:0] agcc_hyst_hi(input logic [1:0] sel);
		case (sel)
			2'h0: agcc_hyst_hi = 4'h1;
			2'h1: agcc_hyst_hi = 4'h2;
			2'h2: agcc_hyst_hi = 4'h3;
			default: agcc_hyst_hi = 4'h4;
		endcase
	endfunction : agcc_hyst_hi

	// margin below target before gain is raised
	function automatic logic [3:0] agcc_hyst_lo(input logic [1:0] sel);
		case (sel)
			2'h0: agcc_hyst_lo = 4'h1;
			2'h1: agcc_hyst_lo = 4'h3;
			2'h2: agcc_hyst_lo = 4'h5;
			default: agcc_hyst_lo = 4'h8;
		endcase
	endfunction : agcc_hyst_lo

	// last sample index of an averaging run: 8, 16, 32, 64 samples
	function automatic logic [5:0] agcc_len_last(input logic [1:0] sel);
		case (sel)
			2'h0: agcc_len_last = 6'h07;
			2'h1: agcc_len_last = 6'h0f;
			2'h2: agcc_len_last = 6'h1f;
			default: agcc_len_last = 6'h3f;
		endcase
	endfunction : agcc_len_last

endpackage : agcc_pkg
`default_nettype wire

// ==== logic/agcc_avg.sv ====
// running average of channel filter magnitude over 8..64 samples
`timescale 1ns/1ps
`default_nettype none
module agcc_avg #(
	parameter int MAG_W = 8
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic in_valid,
	input wire logic [MAG_W-1:0] in_mag,
	input wire logic [1:0] len_sel,
	output logic mean_valid_q,
	output logic [MAG_W-1:0] mean_q
);
	import agcc_pkg::*;

	localparam int ACC_W = MAG_W + 7;

	logic [ACC_W-1:0] acc_q;
	logic [5:0] cnt_q;
	logic [ACC_W-1:0] sum;
	logic [ACC_W-1:0] scaled;
	logic last;

	assign sum = acc_q + {{(ACC_W-MAG_W){1'b0}}, in_mag};
	assign scaled = sum >> ({1'b0, len_sel} + 3'h3);
	assign last = (cnt_q == agcc_len_last(len_sel));

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_q <= '0;
			cnt_q <= 6'h00;
		end
		else if (clear)
		begin
			acc_q <= '0;
			cnt_q <= 6'h00;
		end
		else if (in_valid)
		begin
			acc_q <= last ? '0 : sum;
			cnt_q <= last ? 6'h00 : cnt_q + 6'h01;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mean_valid_q <= 1'b0;
			mean_q <= '0;
		end
		else
		begin
			mean_valid_q <= in_valid && last && !clear;
			if (in_valid && last && !clear)
				mean_q <= scaled[MAG_W-1:0];
		end
	end

endmodule : agcc_avg
`default_nettype wire

// ==== logic/agcc_loop.sv ====
// gain loop configuration register and the gain stepping loop it steers
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - hysteresis field picks dead zone, default 2
// - wait 8/16/24/32 samples after gain step
// - hold 0: always adjust gain when needed
// - hold 1: freeze gain once sync found
// - hold 2: fix analogue gain, adjust digital
// - hold 3: fix both gains for manual override
// - filter length averages 8/16/32/64 samples
// - filter length sets OOK boundary 4-16 dB
module agcc_loop #(
	parameter int MAG_W = 8,
	parameter int ANA_W = 3,
	parameter int DIG_W = 3
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire agcc_pkg::agcc_reg_req_t reg_req,
	output logic [7:0] reg_rdata_q,
	input wire logic sample_valid,
	input wire logic [MAG_W-1:0] sample_mag,
	input wire logic [MAG_W-1:0] mag_target,
	input wire logic sync_found,
	input wire logic rx_start,
	output logic [ANA_W-1:0] ana_gain_q,
	output logic [DIG_W-1:0] dig_gain_q,
	output logic ook_symbol_q,
	output logic sync_hold_q,
	output logic settling_q
);
	import agcc_pkg::*;

	localparam logic [ANA_W-1:0] ANA_MAX = {ANA_W{1'b1}};
	localparam logic [DIG_W-1:0] DIG_MAX = {DIG_W{1'b1}};
	localparam logic [ANA_W-1:0] ANA_ONE = {{(ANA_W-1){1'b0}}, 1'b1};
	localparam logic [DIG_W-1:0] DIG_ONE = {{(DIG_W-1){1'b0}}, 1'b1};

	agcc_ctrl_t ctrl_q;
	agcc_ctrl_t cfg_q;
	agcc_state_t state_q;
	logic [5:0] wait_cnt_q;
	logic mean_valid;
	logic [MAG_W-1:0] mean;
	logic ctrl_hit;
	logic [MAG_W:0] hi_lim;
	logic [MAG_W:0] lo_sum;
	logic too_strong;
	logic too_weak;
	logic ana_lock;
	logic dig_lock;
	logic ana_dn;
	logic ana_up;
	logic dig_dn;
	logic dig_up;
	logic step;
	logic load_cfg;
	logic [MAG_W:0] ook_sum;
	logic [5:0] wait_last;

	assign ctrl_hit = (reg_req.addr == AGCC_CTRL_OFS);

	// host register write
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_q <= AGCC_CTRL_RST;
		else if (reg_req.wr && ctrl_hit)
		begin
			ctrl_q.hyst <= reg_req.wdata[AGCC_HYST_LSB +: 2];
			ctrl_q.wait_sel <= reg_req.wdata[AGCC_WAIT_LSB +: 2];
			ctrl_q.hold <= reg_req.wdata[AGCC_HOLD_LSB +: 2];
			ctrl_q.filt <= reg_req.wdata[AGCC_FILT_LSB +: 2];
		end
	end

	// read answer one cycle after the strobe, zero off the map
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata_q <= 8'h00;
		else if (reg_req.rd)
			reg_rdata_q <= ctrl_hit ? ctrl_q : 8'h00;
	end

	// working copy taken only between gain steps
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			cfg_q <= AGCC_CTRL_RST;
		else if (load_cfg)
			cfg_q <= ctrl_q;
	end

	agcc_avg #(
		.MAG_W(MAG_W)
	) u_avg (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clear(state_q == AGCC_ST_SETTLE),
		.in_valid(sample_valid && state_q == AGCC_ST_ACCUM),
		.in_mag(sample_mag),
		.len_sel(cfg_q.filt),
		.mean_valid_q(mean_valid),
		.mean_q(mean)
	);

	// dead zone around the target
	assign hi_lim = {1'b0, mag_target} + {{(MAG_W-3){1'b0}}, agcc_hyst_hi(cfg_q.hyst)};
	assign lo_sum = {1'b0, mean} + {{(MAG_W-3){1'b0}}, agcc_hyst_lo(cfg_q.hyst)};
	assign too_strong = ({1'b0, mean} > hi_lim);
	assign too_weak = (lo_sum < {1'b0, mag_target});

	// hold policy: which gain stages may move
	always_comb
	begin
		ana_lock = 1'b0;
		dig_lock = 1'b0;
		unique case (cfg_q.hold)
			AGCC_HOLD_NONE:
			begin
				ana_lock = 1'b0;
				dig_lock = 1'b0;
			end
			AGCC_HOLD_SYNC:
			begin
				ana_lock = sync_hold_q;
				dig_lock = sync_hold_q;
			end
			AGCC_HOLD_ANA:
			begin
				ana_lock = 1'b1;
				dig_lock = 1'b0;
			end
			AGCC_HOLD_ALL:
			begin
				ana_lock = 1'b1;
				dig_lock = 1'b1;
			end
		endcase
	end

	// analogue stage moves first, digital takes over at its limits or while analogue is locked
	always_comb
	begin
		ana_dn = 1'b0;
		ana_up = 1'b0;
		dig_dn = 1'b0;
		dig_up = 1'b0;
		if (mean_valid && too_strong)
		begin
			if (!ana_lock && ana_gain_q != '0)
				ana_dn = 1'b1;
			else if (!dig_lock && dig_gain_q != '0)
				dig_dn = 1'b1;
		end
		else if (mean_valid && too_weak)
		begin
			if (!ana_lock && ana_gain_q != ANA_MAX)
				ana_up = 1'b1;
			else if (!dig_lock && dig_gain_q != DIG_MAX)
				dig_up = 1'b1;
		end
	end

	assign step = ana_dn || ana_up || dig_dn || dig_up;
	assign wait_last = ({4'h0, cfg_q.wait_sel} + 6'h01) * AGCC_WAIT_UNIT - 6'h01;
	assign load_cfg = (mean_valid && !step) ||
		(state_q == AGCC_ST_SETTLE && sample_valid && wait_cnt_q == 6'h00);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ana_gain_q <= ANA_MAX;
			dig_gain_q <= DIG_MAX;
		end
		else
		begin
			if (ana_dn)
				ana_gain_q <= ana_gain_q - ANA_ONE;
			else if (ana_up)
				ana_gain_q <= ana_gain_q + ANA_ONE;
			if (dig_dn)
				dig_gain_q <= dig_gain_q - DIG_ONE;
			else if (dig_up)
				dig_gain_q <= dig_gain_q + DIG_ONE;
		end
	end

	// settle wait counted in channel filter samples
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= AGCC_ST_ACCUM;
			settling_q <= 1'b0;
			wait_cnt_q <= 6'h00;
		end
		else
		begin
			unique case (state_q)
				AGCC_ST_ACCUM:
					if (step)
					begin
						state_q <= AGCC_ST_SETTLE;
						settling_q <= 1'b1;
						wait_cnt_q <= wait_last;
					end
				AGCC_ST_SETTLE:
					if (sample_valid)
					begin
						if (wait_cnt_q == 6'h00)
						begin
							state_q <= AGCC_ST_ACCUM;
							settling_q <= 1'b0;
						end
						else
							wait_cnt_q <= wait_cnt_q - 6'h01;
					end
			endcase
		end
	end

	// sync freeze latch, set wins over clear
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			sync_hold_q <= 1'b0;
		else if (sync_found && ctrl_q.hold == AGCC_HOLD_SYNC)
			sync_hold_q <= 1'b1;
		else if (rx_start || ctrl_q.hold != AGCC_HOLD_SYNC)
			sync_hold_q <= 1'b0;
	end

	// ook slicer: boundary below target, 4 dB per step
	assign ook_sum = {1'b0, sample_mag} +
		{{(MAG_W-4){1'b0}}, ({3'h0, cfg_q.filt} + 5'h01) * AGCC_OOK_STEP_DB};

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			ook_symbol_q <= 1'b0;
		else if (sample_valid)
			ook_symbol_q <= (ook_sum >= {1'b0, mag_target});
	end

endmodule : agcc_loop
`default_nettype wire

// ==== tb/agcc_monitor.sv ====
// port assertions for the gain loop config block
`timescale 1ns/1ps
`default_nettype none
module agcc_monitor #(
	parameter int ANA_W = 3,
	parameter int DIG_W = 3
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire agcc_pkg::agcc_reg_req_t reg_req,
	input wire logic [7:0] reg_rdata_q,
	input wire logic sample_valid,
	input wire logic sync_found,
	input wire logic rx_start,
	input wire logic [ANA_W-1:0] ana_gain_q,
	input wire logic [DIG_W-1:0] dig_gain_q,
	input wire logic sync_hold_q,
	input wire logic settling_q
);
	import agcc_pkg::*;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	rd_unmapped_a: assert property (reg_req.rd && reg_req.addr != AGCC_CTRL_OFS
		|=> reg_rdata_q == 8'h00) else $error("unmapped read not zero");
	rd_hold_a: assert property (!reg_req.rd |=> $stable(reg_rdata_q))
		else $error("read data moved");
	one_step_a: assert property ($changed(ana_gain_q)
		|-> !$changed(dig_gain_q)) else $error("two gains moved");
	step_cause_a: assert property ($changed(ana_gain_q)
		|-> $past(sample_valid, 2)) else $error("step without sample");
	settle_rise_a: assert property ($changed(ana_gain_q)
		|| $changed(dig_gain_q) |-> $rose(settling_q))
		else $error("no settle after step");
	settle_hold_a: assert property (settling_q && $past(settling_q)
		|-> $stable(ana_gain_q) && $stable(dig_gain_q))
		else $error("gain moved in settle");
	settle_end_a: assert property ($fell(settling_q)
		|-> $past(sample_valid)) else $error("settle ended off sample");
	sync_clear_a: assert property (rx_start && !sync_found
		|=> !sync_hold_q) else $error("sync hold not cleared");
	sync_freeze_a: assert property (sync_hold_q && $past(sync_hold_q)
		|-> $stable(ana_gain_q) && $stable(dig_gain_q))
		else $error("gain moved in sync hold");
	cover property ($rose(settling_q));
	cover property ($fell(settling_q));
	cover property ($rose(sync_hold_q));
endmodule : agcc_monitor
bind agcc_loop agcc_monitor #(.ANA_W(ANA_W), .DIG_W(DIG_W)) u_agcc_monitor (
	.core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req),
	.reg_rdata_q(reg_rdata_q), .sample_valid(sample_valid),
	.sync_found(sync_found), .rx_start(rx_start), .ana_gain_q(ana_gain_q),
	.dig_gain_q(dig_gain_q), .sync_hold_q(sync_hold_q),
	.settling_q(settling_q));
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the gain loop config block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import agcc_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	agcc_reg_req_t rq = '0;
	logic sv = 1'b0;
	logic [7:0] mag = 8'h00;
	logic sf = 1'b0;
	logic rs = 1'b0;
	logic pend = 1'b0;
	logic [7:0] rdata;
	logic [2:0] ag, dg;
	logic ook, sh, st;
	logic [7:0] eq[$];
	int n_errors = 0;
	int n_checks = 0;
	always #20 core_clk = ~core_clk;
	agcc_loop u_agcc_loop (.core_clk(core_clk), .rst_n(rst_n), .reg_req(rq),
		.reg_rdata_q(rdata), .sample_valid(sv), .sample_mag(mag),
		.mag_target(8'h64), .sync_found(sf), .rx_start(rs), .ana_gain_q(ag),
		.dig_gain_q(dg), .ook_symbol_q(ook), .sync_hold_q(sh),
		.settling_q(st));
	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
			n_errors++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		rq <= '{1'b1, 1'b0, a, d};
		@(posedge core_clk);
		rq <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		eq.push_back(e);
		@(posedge core_clk);
		rq <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge core_clk);
		rq <= '0;
	endtask : rd
	task automatic smp(input int n, input logic [7:0] m);
		repeat (n)
		begin
			@(posedge core_clk);
			sv <= 1'b1;
			mag <= m;
		end
		@(posedge core_clk);
		sv <= 1'b0;
	endtask : smp
	task automatic gn(input logic [2:0] a, input logic [2:0] d, input logic s);
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		chk("gains", {1'b0, a, 1'b0, d}, {1'b0, ag, 1'b0, dg});
		chk("settling_q", {7'h0, s}, {7'h0, st});
	endtask : gn
	// read answers are compared one cycle after the strobe is taken
	always @(posedge core_clk)
	begin
		if (pend)
			chk("reg_rdata_q", eq.pop_front(), rdata);
		pend <= rq.rd;
	end
	initial
	begin
		#100000;
		n_errors++;
		final_report();
	end
	initial
	begin
		logic [7:0] v;
		void'($urandom(32'h5ebc));
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(8'h1c, 8'h91);
		rd(8'h1d, 8'h00);
		v = 8'($urandom);
		wr(8'h1c, v);
		rd(8'h1c, v);
		$display("register test done");
		wr(8'h1c, 8'h00);
		smp(64, 8'h64);
		smp(1, 8'h60);
		@(negedge core_clk);
		chk("ook_symbol_q", 8'h01, {7'h0, ook});
		smp(1, 8'h5f);
		@(negedge core_clk);
		chk("ook_symbol_q", 8'h00, {7'h0, ook});
		$display("ook test done");
		// two slicer samples already sit in the running average
		smp(62, 8'h64);
		smp(7, 8'hc8);
		gn(3'h7, 3'h7, 1'b0);
		smp(1, 8'hc8);
		gn(3'h6, 3'h7, 1'b1);
		smp(7, 8'h64);
		gn(3'h6, 3'h7, 1'b1);
		smp(1, 8'h64);
		gn(3'h6, 3'h7, 1'b0);
		wr(8'h1c, 8'h08);
		smp(64, 8'h64);
		smp(8, 8'hc8);
		gn(3'h6, 3'h6, 1'b1);
		wr(8'h1c, 8'h0c);
		smp(64, 8'h64);
		smp(8, 8'hc8);
		gn(3'h6, 3'h6, 1'b0);
		wr(8'h1c, 8'h04);
		smp(64, 8'h64);
		@(posedge core_clk);
		sf <= 1'b1;
		@(posedge core_clk);
		sf <= 1'b0;
		smp(8, 8'hc8);
		gn(3'h6, 3'h6, 1'b0);
		chk("sync_hold_q", 8'h01, {7'h0, sh});
		@(posedge core_clk);
		rs <= 1'b1;
		@(posedge core_clk);
		rs <= 1'b0;
		@(negedge core_clk);
		chk("sync_hold_q", 8'h00, {7'h0, sh});
		smp(8, 8'hc8);
		gn(3'h5, 3'h6, 1'b1);
		$display("gain loop test done");
		final_report();
	end
endmodule : tb_top
`default_nettype wire
